// ### logic/term_decoder_defines.vh
`ifndef TERM_DECODER_DEFINES_VH
`define TERM_DECODER_DEFINES_VH

// --------------------------------------------------------------
// input function codes
// --------------------------------------------------------------
`define FN_RUN 6'h01
`define FN_FWD 6'h02
`define FN_REV 6'h03
`define FN_STOP 6'h04
`define FN_DIR_TOGGLE 6'h05
`define FN_TIMER_ONE 6'h09
`define FN_TIMER_TWO 6'h0A
`define FN_RAMP_SEL_ONE 6'h11
`define FN_RAMP_SEL_TWO 6'h12
`define FN_HIGH_SPEED 6'h16
`define FN_MEDIUM_SPEED 6'h17
`define FN_LOW_SPEED 6'h18
`define FN_UP 6'h1B
`define FN_DOWN 6'h1C
`define FN_PULSE_COUNT 6'h1F
`define FN_COUNT_RESET 6'h20

// --------------------------------------------------------------
// output function codes
// --------------------------------------------------------------
`define OUT_RUNNING 6'h01
`define OUT_ZERO_SPEED 6'h02
`define OUT_FAULT 6'h03
`define OUT_FREQ_REACHED 6'h05
`define OUT_ACCEL 6'h06
`define OUT_DECEL 6'h07
`define OUT_COUNT_REACHED 6'h0D
`define OUT_TIMER_ONE 6'h0F
`define OUT_TIMER_TWO 6'h10

// --------------------------------------------------------------
// mode settings and limits
// --------------------------------------------------------------
`define SRC_TERMINAL 2'h1
`define SPEED_MODE_EXT4 2'h2
`define SPEED_MODE_INTERNAL 2'h1
`define FREQ_SRC_KEYPAD 2'h0
`define COUNT_MAX 16'hFFFF
`define FREQ_WIDTH 16

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CLK_MHZ 40
`define PULSE_MIN_US 2000
`define UPDN_STEP_RAPID 16'h0010
`define UPDN_RAPID_STEPS 4'h8
`define RESET_FREQ 16'h0000

`endif

// ### logic/level_sync.v
`timescale 1ns/1ps

// --------------------------------------------------------------
// two-stage synchroniser for a group of pin levels
// --------------------------------------------------------------
module level_sync #(
  parameter WIDTH = 6
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // levels
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage_one;
  reg [WIDTH-1:0] stage_two;

  // first stage is read only by the second one
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_one <= {WIDTH{1'b0}};
      stage_two <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_i;
      stage_two <= stage_one;
    end
  end

  assign sync_o = stage_two;

endmodule // level_sync

// ### logic/terminal_command_decoder.v
// Summary of operation
// - three-wire: edges on fwd/rev inputs start running
// - three-wire: opening stop contact stops drive
// - run contact runs; toggle contact picks direction
// - forward contact runs forward, reverse contact reverse
// - two ramp bits pick one of four times
// - codes 17 and 18 make ramp-select bits
// - ramp select only in speed modes 0,2,3
// - speed inputs pick preset, else main setpoint
// - speed inputs honoured only in speed mode 2
// - high beats medium beats low
// - up raises, down lowers, both hold
// - up/down only with keypad frequency source
// - up/down ignored while in standby
// - up/down clamp at maximum and minimum
// - up/down rate follows selected ramp time
// - held up/down: rapid jump then uniform rate
// - count reached drives count output contact
// - count halts at target, restarts after reset
// - output codes 1,2,3: run, zero speed, fault
// - output codes 5,6,7: reached, accel, decel
// - output codes 13,15,16: count, timers
`timescale 1ns/1ps
`include "term_decoder_defines.vh"

module terminal_command_decoder (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // terminal pins, active high after polarity handling
  input wire input_terminal_one_i,
  input wire input_terminal_two_i,
  input wire input_terminal_three_i,
  input wire input_terminal_four_i,
  input wire input_terminal_five_i,
  input wire input_terminal_six_i,
  // configuration
  input wire [1:0] command_source_setting_i,
  input wire [5:0] input_one_function_i,
  input wire [5:0] input_two_function_i,
  input wire [5:0] input_three_function_i,
  input wire [5:0] input_four_function_i,
  input wire [5:0] input_five_function_i,
  input wire [5:0] input_six_function_i,
  input wire [1:0] speed_mode_setting_i,
  input wire [1:0] frequency_source_setting_i,
  input wire [5:0] output_one_function_i,
  input wire [5:0] output_two_function_i,
  input wire [5:0] relay_a_function_i,
  input wire [5:0] relay_b_function_i,
  // frequency settings
  input wire [15:0] main_frequency_setpoint_i,
  input wire [15:0] low_preset_frequency_i,
  input wire [15:0] medium_preset_frequency_i,
  input wire [15:0] high_preset_frequency_i,
  input wire [15:0] max_frequency_i,
  input wire [15:0] min_frequency_i,
  input wire [15:0] count_target_value_i,
  // ramp step strobes per ramp time, from the ramp generator
  input wire [3:0] ramp_tick_i,
  // drive status from motor control
  input wire running_status_i,
  input wire below_startup_i,
  input wire fault_i,
  input wire freq_reached_i,
  input wire accelerating_i,
  input wire decelerating_i,
  input wire timer_one_reached_i,
  input wire timer_two_reached_i,
  // commands out
  output reg run_cmd_o,
  output reg reverse_o,
  output reg [1:0] ramp_select_o,
  output reg [15:0] target_frequency_o,
  output reg [15:0] updown_frequency_o,
  output reg timer_one_start_o,
  output reg timer_two_start_o,
  output reg [15:0] pulse_count_o,
  output reg count_reached_o,
  // output contacts
  output reg output_one_o,
  output reg output_two_o,
  output reg relay_a_o,
  output reg relay_b_o
);

  // --------------------------------------------------------------
  // decoding helpers
  // --------------------------------------------------------------

  // true when any terminal with the given function is active
  function func_active;
    input [5:0] code;
    input [35:0] funcs;
    input [5:0] levels;
    integer i;
    begin
      func_active = 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        if (funcs[i*6 +: 6] == code && levels[i])
          func_active = 1'b1;
      end
    end
  endfunction

  // true when any terminal carries the function at all
  function func_assigned;
    input [5:0] code;
    input [35:0] funcs;
    integer i;
    begin
      func_assigned = 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        if (funcs[i*6 +: 6] == code)
          func_assigned = 1'b1;
      end
    end
  endfunction

  // selects the indication for one output contact
  function out_select;
    input [5:0] code;
    input [8:0] ind;
    begin
      case (code)
        `OUT_RUNNING: out_select = ind[0];
        `OUT_ZERO_SPEED: out_select = ind[1];
        `OUT_FAULT: out_select = ind[2];
        `OUT_FREQ_REACHED: out_select = ind[3];
        `OUT_ACCEL: out_select = ind[4];
        `OUT_DECEL: out_select = ind[5];
        `OUT_COUNT_REACHED: out_select = ind[6];
        `OUT_TIMER_ONE: out_select = ind[7];
        `OUT_TIMER_TWO: out_select = ind[8];
        default: out_select = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // synchronised terminals
  // --------------------------------------------------------------
  wire [5:0] pins_raw;
  wire [5:0] pins;
  reg [5:0] pins_prev;
  wire [35:0] funcs;

  assign pins_raw = {input_terminal_six_i, input_terminal_five_i,
                     input_terminal_four_i, input_terminal_three_i,
                     input_terminal_two_i, input_terminal_one_i};
  assign funcs = {input_six_function_i, input_five_function_i,
                  input_four_function_i, input_three_function_i,
                  input_two_function_i, input_one_function_i};

  // every decision uses clocked levels only
  level_sync #(
    .WIDTH(6)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_prev <= 6'h00;
    end else begin
      pins_prev <= pins;
    end
  end

  wire [5:0] rise = pins & ~pins_prev;
  wire [5:0] fall = ~pins & pins_prev;

  // --------------------------------------------------------------
  // run and direction
  // --------------------------------------------------------------
  wire terminal_ctl = (command_source_setting_i == `SRC_TERMINAL);
  wire has_stop = func_assigned(`FN_STOP, funcs);
  wire has_run = func_assigned(`FN_RUN, funcs);
  wire fwd_lvl = func_active(`FN_FWD, funcs, pins);
  wire rev_lvl = func_active(`FN_REV, funcs, pins);
  wire fwd_edge = func_active(`FN_FWD, funcs, rise);
  wire rev_edge = func_active(`FN_REV, funcs, rise);
  wire stop_open = func_active(`FN_STOP, funcs, fall);
  wire stop_closed = func_active(`FN_STOP, funcs, pins);
  wire run_lvl = func_active(`FN_RUN, funcs, pins);
  wire toggle_lvl = func_active(`FN_DIR_TOGGLE, funcs, pins);

  reg next_run;
  reg next_rev;

  // three-wire latches on edges; two-wire follows contact levels
  always @* begin
    next_run = run_cmd_o;
    next_rev = reverse_o;
    if (!terminal_ctl) begin
      next_run = 1'b0;
    end else if (has_stop) begin
      if (stop_open || !stop_closed) begin
        next_run = 1'b0;
      end else if (fwd_edge) begin
        next_run = 1'b1;
        next_rev = 1'b0;
      end else if (rev_edge) begin
        next_run = 1'b1;
        next_rev = 1'b1;
      end
    end else if (has_run) begin
      next_run = run_lvl;
      next_rev = toggle_lvl;
    end else begin
      next_run = fwd_lvl | rev_lvl;
      if (fwd_lvl)
        next_rev = 1'b0;
      else if (rev_lvl)
        next_rev = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // ramp time and speed selection
  // --------------------------------------------------------------
  wire ramp_allowed = (speed_mode_setting_i != `SPEED_MODE_INTERNAL);
  wire ramp_bit_one = func_active(`FN_RAMP_SEL_ONE, funcs, pins);
  wire ramp_bit_two = func_active(`FN_RAMP_SEL_TWO, funcs, pins);
  wire [1:0] next_ramp = ramp_allowed ?
                         {ramp_bit_two, ramp_bit_one} : 2'h0;

  wire ext_speed = (speed_mode_setting_i == `SPEED_MODE_EXT4);
  wire high_on = ext_speed & func_active(`FN_HIGH_SPEED, funcs, pins);
  wire med_on = ext_speed & func_active(`FN_MEDIUM_SPEED, funcs, pins);
  wire low_on = ext_speed & func_active(`FN_LOW_SPEED, funcs, pins);

  reg [15:0] next_target;

  // priority high, medium, low, then main
  always @* begin
    if (high_on)
      next_target = high_preset_frequency_i;
    else if (med_on)
      next_target = medium_preset_frequency_i;
    else if (low_on)
      next_target = low_preset_frequency_i;
    else
      next_target = main_frequency_setpoint_i;
  end

  // --------------------------------------------------------------
  // up/down frequency adjustment
  // --------------------------------------------------------------
  wire up_on = func_active(`FN_UP, funcs, pins);
  wire dn_on = func_active(`FN_DOWN, funcs, pins);
  // standby and non-keypad sources ignore the buttons entirely
  wire updn_ok = (frequency_source_setting_i == `FREQ_SRC_KEYPAD) &&
                 running_status_i;
  wire up_go = updn_ok & up_on & ~dn_on;
  wire dn_go = updn_ok & dn_on & ~up_on;
  wire rate_tick = ramp_tick_i[ramp_select_o];
  reg [3:0] rapid_left;
  reg [15:0] next_updn;
  reg [15:0] step;

  // first a few coarse steps, then unit steps at ramp rate
  always @* begin
    step = (rapid_left != 4'h0) ? `UPDN_STEP_RAPID : 16'h0001;
    next_updn = updown_frequency_o;
    if (up_go && rate_tick) begin
      if (max_frequency_i - updown_frequency_o > step)
        next_updn = updown_frequency_o + step;
      else
        next_updn = max_frequency_i;
    end else if (dn_go && rate_tick) begin
      if (updown_frequency_o - min_frequency_i > step &&
          updown_frequency_o > min_frequency_i)
        next_updn = updown_frequency_o - step;
      else
        next_updn = min_frequency_i;
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rapid_left <= `UPDN_RAPID_STEPS;
      updown_frequency_o <= `RESET_FREQ;
    end else begin
      updown_frequency_o <= next_updn;
      if (!(up_go || dn_go))
        rapid_left <= `UPDN_RAPID_STEPS;
      else if (rate_tick && rapid_left != 4'h0)
        rapid_left <= rapid_left - 4'h1;
    end
  end

  // --------------------------------------------------------------
  // pulse counter
  // --------------------------------------------------------------
  // no filter here: the source holds each level long enough
  wire cnt_edge = func_active(`FN_PULSE_COUNT, funcs, rise);
  wire cnt_clear = func_active(`FN_COUNT_RESET, funcs, pins);
  reg count_done;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_count_o <= 16'h0000;
      count_done <= 1'b0;
    end else if (cnt_clear) begin
      pulse_count_o <= 16'h0000;
      count_done <= 1'b0;
    end else if (cnt_edge && !count_done &&
                 pulse_count_o != `COUNT_MAX) begin
      pulse_count_o <= pulse_count_o + 16'h0001;
      if (pulse_count_o + 16'h0001 >= count_target_value_i)
        count_done <= 1'b1; // counting halts until reset
    end
  end

  // --------------------------------------------------------------
  // output registers and contacts
  // --------------------------------------------------------------
  wire count_hit = count_done ||
                   (pulse_count_o >= count_target_value_i);
  wire [8:0] ind = {timer_two_reached_i, timer_one_reached_i, count_hit,
                    decelerating_i, accelerating_i, freq_reached_i,
                    fault_i, below_startup_i, running_status_i};

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_cmd_o <= 1'b0;
      reverse_o <= 1'b0;
      ramp_select_o <= 2'h0;
      target_frequency_o <= `RESET_FREQ;
      timer_one_start_o <= 1'b0;
      timer_two_start_o <= 1'b0;
      count_reached_o <= 1'b0;
      output_one_o <= 1'b0;
      output_two_o <= 1'b0;
      relay_a_o <= 1'b0;
      relay_b_o <= 1'b0;
    end else begin
      run_cmd_o <= next_run;
      reverse_o <= next_rev;
      ramp_select_o <= next_ramp;
      target_frequency_o <= next_target;
      timer_one_start_o <= func_active(`FN_TIMER_ONE, funcs, pins);
      timer_two_start_o <= func_active(`FN_TIMER_TWO, funcs, pins);
      count_reached_o <= count_hit;
      output_one_o <= out_select(output_one_function_i, ind);
      output_two_o <= out_select(output_two_function_i, ind);
      relay_a_o <= out_select(relay_a_function_i, ind);
      relay_b_o <= out_select(relay_b_function_i, ind);
    end
  end

endmodule // terminal_command_decoder

// ### sim/terminal_command_decoder_assertions.sv
`timescale 1ns/1ps

// ----------------------------------------------
// port checker for the terminal decoder
// ----------------------------------------------
module terminal_command_decoder_assertions (
  // clock and reset
  input logic mclk_i,
  input logic rst_n_i,
  // settings and status
  input logic [1:0] frequency_source_setting_i,
  input logic [5:0] output_one_function_i,
  input logic [5:0] relay_a_function_i,
  input logic [5:0] relay_b_function_i,
  input logic [15:0] max_frequency_i,
  input logic [15:0] min_frequency_i,
  input logic running_status_i,
  input logic fault_i,
  input logic timer_one_reached_i,
  // watched outputs
  input logic [15:0] updown_frequency_o,
  input logic [15:0] pulse_count_o,
  input logic count_reached_o,
  input logic output_one_o,
  input logic relay_a_o,
  input logic relay_b_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // contacts follow the selected status one edge later
  property p_run_contact;
    $past(rst_n_i) && $stable(output_one_function_i) &&
      output_one_function_i == 6'h01 |-> output_one_o == $past(running_status_i);
  endproperty
  a_run_contact: assert property (p_run_contact)
    else $error("run contact wrong");
  property p_fault_contact;
    $past(rst_n_i) && $stable(relay_a_function_i) &&
      relay_a_function_i == 6'h03 |-> relay_a_o == $past(fault_i);
  endproperty
  a_fault_contact: assert property (p_fault_contact)
    else $error("fault contact wrong");
  property p_timer_contact;
    $past(rst_n_i) && $stable(relay_b_function_i) &&
      relay_b_function_i == 6'h0F |-> relay_b_o == $past(timer_one_reached_i);
  endproperty
  a_timer_contact: assert property (p_timer_contact)
    else $error("timer contact wrong");

  // up/down value frozen in standby or with a non-keypad source
  property p_standby_hold;
    !running_status_i [*2] |=> $stable(updown_frequency_o);
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("up/down moved in standby");
  property p_source_hold;
    frequency_source_setting_i != 2'h0 [*2] |=> $stable(updown_frequency_o);
  endproperty
  a_source_hold: assert property (p_source_hold)
    else $error("up/down moved with wrong source");
  property p_clamp;
    $past(rst_n_i) && !$stable(updown_frequency_o) |->
      updown_frequency_o <= max_frequency_i &&
      updown_frequency_o >= min_frequency_i;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("up/down left its limits");

  // counter moves one step at a time and halts once reached
  property p_cnt_step;
    $past(rst_n_i) && pulse_count_o != $past(pulse_count_o) |->
      pulse_count_o == $past(pulse_count_o) + 16'h0001 || pulse_count_o == 16'h0000;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("count jumped");
  property p_cnt_hold;
    count_reached_o && pulse_count_o != 16'h0000 |=>
      $stable(pulse_count_o) || pulse_count_o == 16'h0000;
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("count went on after target");
endmodule // terminal_command_decoder_assertions

bind terminal_command_decoder terminal_command_decoder_assertions i_chk (
  .mclk_i, .rst_n_i, .frequency_source_setting_i, .output_one_function_i,
  .relay_a_function_i, .relay_b_function_i, .max_frequency_i,
  .min_frequency_i, .running_status_i, .fault_i, .timer_one_reached_i,
  .updown_frequency_o, .pulse_count_o, .count_reached_o, .output_one_o,
  .relay_a_o, .relay_b_o
);

// ### sim/terminal_pins_model.sv
`timescale 1ns/1ps

// ----------------------------------------------
// operator switches plus a pulse sensor
// ----------------------------------------------
module terminal_pins_model #(
  parameter HOLD = 80000,
  parameter PULSE_PIN = 5
) (
  // clock
  input wire mclk_i,
  // wanted switch levels and pulse enable
  input wire [5:0] level_i,
  input wire pulse_i,
  // terminal pins
  output wire [5:0] pins_o
);
  reg phase = 1'b0;
  integer cnt = 0;

  // each sensor level stands HOLD cycles, 80000 being 2 ms at 40 MHz
  always @(posedge mclk_i) begin
    if (!pulse_i || cnt == HOLD - 1) begin
      phase <= pulse_i & ~phase;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // sensor line rests low between bursts
  assign pins_o = level_i | ({5'h00, phase} << PULSE_PIN);
endmodule // terminal_pins_model

// ### sim/terminal_command_decoder_tb_top.sv
`timescale 1ns/1ps

module terminal_command_decoder_tb_top;
  // ----------------------------------------------
  // stimulus, results and counters
  // ----------------------------------------------
  reg mclk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [5:0] lvl = 6'h00;
  reg [5:0] fn [0:5] = '{default: 6'h00};
  reg [5:0] oc = 6'h00;
  reg [1:0] src = 2'h1;
  reg [1:0] smode = 2'h0;
  reg [1:0] fsrc = 2'h0;
  reg [7:0] st = 8'h00;
  reg [3:0] tick = 4'h0;
  reg [15:0] fm = 16'h0064, fl = 16'h0011, fmd = 16'h0022, fh = 16'h0033;
  reg pulse = 1'b0;
  // rows: output code in the upper six bits, status bit that drives it below
  reg [8:0] rows [0:7] = '{9'h008, 9'h011, 9'h01A, 9'h02B,
                           9'h034, 9'h03D, 9'h07E, 9'h087};
  wire [5:0] pin;
  wire run, rev, creach, c1, c2, ca, cb;
  wire t1s, t2s;
  wire [1:0] rsel;
  wire [15:0] tfreq, ufreq, pcnt;
  wire [15:0] rr = {14'h0000, run, rev};
  wire [15:0] cts = {11'h000, creach, c1, c2, ca, cb};
  integer fail_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer i;
  integer j;

  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;

  // design has no glitch filter, so a short sensor hold keeps the run brief
  terminal_pins_model #(.HOLD(4), .PULSE_PIN(5)) i_pins (
    .mclk_i(mclk_i), .level_i(lvl), .pulse_i(pulse), .pins_o(pin));

  terminal_command_decoder i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .input_terminal_one_i(pin[0]), .input_terminal_two_i(pin[1]),
    .input_terminal_three_i(pin[2]), .input_terminal_four_i(pin[3]),
    .input_terminal_five_i(pin[4]), .input_terminal_six_i(pin[5]),
    .command_source_setting_i(src), .input_one_function_i(fn[0]),
    .input_two_function_i(fn[1]), .input_three_function_i(fn[2]),
    .input_four_function_i(fn[3]), .input_five_function_i(fn[4]),
    .input_six_function_i(fn[5]), .speed_mode_setting_i(smode),
    .frequency_source_setting_i(fsrc), .output_one_function_i(oc),
    .output_two_function_i(oc), .relay_a_function_i(oc),
    .relay_b_function_i(oc), .main_frequency_setpoint_i(fm),
    .low_preset_frequency_i(fl), .medium_preset_frequency_i(fmd),
    .high_preset_frequency_i(fh), .max_frequency_i(16'h0082),
    .min_frequency_i(16'h0005), .count_target_value_i(16'h0003),
    .ramp_tick_i(tick), .running_status_i(st[0]), .below_startup_i(st[1]),
    .fault_i(st[2]), .freq_reached_i(st[3]), .accelerating_i(st[4]),
    .decelerating_i(st[5]), .timer_one_reached_i(st[6]),
    .timer_two_reached_i(st[7]), .run_cmd_o(run), .reverse_o(rev),
    .ramp_select_o(rsel), .target_frequency_o(tfreq),
    .updown_frequency_o(ufreq), .timer_one_start_o(t1s),
    .timer_two_start_o(t2s),
    .pulse_count_o(pcnt), .count_reached_o(creach), .output_one_o(c1),
    .output_two_o(c2), .relay_a_o(ca), .relay_b_o(cb));

  // ----------------------------------------------
  // helpers
  // ----------------------------------------------
  task wt(input integer n);
    repeat (n) @(posedge mclk_i);
  endtask

  task cmp(input string nm, input [15:0] e, input [15:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle rate strobes, spaced so a slow step logic keeps up
  task ticks(input integer n);
    repeat (n) begin
      tick <= 4'hF;
      wt(1);
      tick <= 4'h0;
      wt(3);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far beyond the thousand or so cycles the tests need
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end

  // ----------------------------------------------
  // tests
  // ----------------------------------------------
  initial begin
    // the reset branch lands on the first edge, so look one edge later
    wt(2);
    cmp("count in reset", 16'h0000, pcnt);
    cmp("contacts in reset", 16'h0000, cts);
    wt(2);
    rst_n_i <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      oc <= rows[i][8:3];
      st <= 8'h01 << rows[i][2:0];
      wt(3);
      cmp("contacts on", 16'h000F, cts);
      st <= ~(8'h01 << rows[i][2:0]);
      wt(3);
      cmp("contacts off", 16'h0000, cts);
    end
    $display("test contacts done");
    // three-wire: edges start, stop contact opening halts
    fn[0] <= 6'h02;
    fn[1] <= 6'h03;
    fn[2] <= 6'h04;
    lvl <= 6'h04;
    wt(8);
    lvl <= 6'h05;
    wt(4);
    lvl <= 6'h04;
    wt(8);
    cmp("fwd edge", 16'h0002, rr);
    lvl <= 6'h06;
    wt(4);
    lvl <= 6'h04;
    wt(8);
    cmp("rev edge", 16'h0003, rr);
    lvl <= 6'h00;
    wt(8);
    cmp("stop", 16'h0000, {15'h0000, run});
    // two-wire with run and direction toggle
    fn[0] <= 6'h01;
    fn[1] <= 6'h05;
    fn[2] <= 6'h00;
    for (j = 0; j < 4; j = j + 1) begin
      lvl <= {4'h0, j[1:0]};
      wt(8);
      cmp("run toggle", {14'h0000, j[0], j[0] & j[1]}, rr & {15'h7FFF, run});
    end
    // two-wire with forward and reverse contacts
    fn[0] <= 6'h02;
    fn[1] <= 6'h03;
    lvl <= 6'h02;
    wt(8);
    cmp("reverse", 16'h0003, rr);
    lvl <= 6'h01;
    wt(8);
    cmp("forward", 16'h0002, rr);
    // terminals only command the drive under terminal control
    src <= 2'h0;
    wt(8);
    cmp("no terminal", 16'h0000, {15'h0000, run});
    src <= 2'h1;
    $display("test run control done");
    // ramp bits in every allowed speed mode
    fn[3] <= 6'h11;
    fn[4] <= 6'h12;
    for (j = 0; j < 4; j = j + 1) begin
      smode <= (j == 1) ? 2'h2 : (j == 2) ? 2'h3 : 2'h0;
      lvl <= {1'b0, j[1:0], 3'h0};
      wt(8);
      cmp("ramp", j[15:0], {14'h0000, rsel});
    end
    // internal multi-segment mode ignores both ramp bits
    smode <= 2'h1;
    wt(8);
    cmp("ramp off", 16'h0000, {14'h0000, rsel});
    // speed presets with priority
    fn[0] <= 6'h01;
    fn[3] <= 6'h16;
    fn[4] <= 6'h17;
    fn[5] <= 6'h18;
    smode <= 2'h2;
    st <= 8'h01;
    for (j = 0; j < 8; j = j + 1) begin
      lvl <= {j[0], j[1], j[2], 3'h1};
      wt(8);
      cmp("preset", j[2] ? fh : j[1] ? fmd : j[0] ? fl : fm, tfreq);
    end
    smode <= 2'h0;
    lvl <= 6'h09;
    wt(8);
    cmp("preset off", fm, tfreq);
    $display("test ramp and speed done");
    // up/down: rapid then uniform steps, clamps, refusals
    fn[3] <= 6'h1B;
    fn[4] <= 6'h1C;
    fn[5] <= 6'h00;
    wt(6);
    ticks(9);
    cmp("up", 16'h0081, ufreq);
    ticks(3);
    cmp("up max", 16'h0082, ufreq);
    lvl <= 6'h19;
    wt(6);
    ticks(3);
    cmp("both", 16'h0082, ufreq);
    st <= 8'h00;
    lvl <= 6'h11;
    wt(6);
    ticks(3);
    cmp("standby", 16'h0082, ufreq);
    st <= 8'h01;
    fsrc <= 2'h1;
    ticks(3);
    cmp("source", 16'h0082, ufreq);
    fsrc <= 2'h0;
    ticks(130);
    cmp("down min", 16'h0005, ufreq);
    $display("test up down done");
    // pulse counter: halt at target, clear, count again
    oc <= 6'h0D;
    fn[3] <= 6'h00;
    fn[4] <= 6'h20;
    fn[5] <= 6'h1F;
    lvl <= 6'h00;
    pulse <= 1'b1;
    wt(40);
    pulse <= 1'b0;
    wt(8);
    cmp("count", 16'h0003, pcnt);
    cmp("reached", 16'h001F, cts);
    lvl <= 6'h10;
    wt(8);
    lvl <= 6'h00;
    wt(8);
    cmp("cleared", 16'h0000, pcnt);
    pulse <= 1'b1;
    wt(16);
    pulse <= 1'b0;
    wt(8);
    cmp("recount", 16'h0002, pcnt);
    $display("test counter done");
    // a pin level needs both sync stages before it is decoded
    fn[1] <= 6'h09;
    fn[2] <= 6'h0A;
    lvl <= 6'h02;
    wt(2);
    @(negedge mclk_i);
    cmp("timer early", 16'h0000, {14'h0000, t1s, t2s});
    @(negedge mclk_i);
    cmp("timer start", 16'h0002, {14'h0000, t1s, t2s});
    // reset in mid-run clears counter, up/down value and decoded levels
    wt(1);
    rst_n_i <= 1'b0;
    wt(2);
    cmp("count after reset", 16'h0000, pcnt);
    cmp("up/down after reset", 16'h0000, ufreq);
    cmp("timer after reset", 16'h0000, {14'h0000, t1s, t2s});
    rst_n_i <= 1'b1;
    wt(2);
    $display("test sync and reset done");
    end_sim;
  end
endmodule // terminal_command_decoder_tb_top
